// ### design/mps_sequencer.v
// program sequencer core: four-phase instruction cycle, fetch and
// execute overlap, 12-bit counter, 8-level return stack and 8-bit alu.
// assumes program memory and interrupt logic run on i_ref_clk; memory
// data must be valid by the last phase of the cycle that presents the address.
`timescale 1ns/10ps
`include "mps_consts.vh"

// What this block does
// - four phases form one instruction cycle
// - counter advances and fetch starts at first phase
// - fetch overlaps execute; counter changes cost cycle
// - standard one cycle, extended and branches two
// - counter steps by one unless transferring
// - 12-bit counter, only low byte addressable
// - jumps, calls, interrupts, reset load target
// - taken skip discards fetched word, dummy cycle
// - low byte write jumps within page, dummy
// - 8-level return stack, hidden from software
// - call or interrupt acknowledge pushes counter
// - returns restore counter from top entry
// - reset points stack pointer to top
// - full stack withholds interrupt acknowledge until pop
// - call on full stack loses oldest entry
// - 8-bit alu with arithmetic, logic, rotate ops
// - alu updates carry, borrow and status bits
// - program memory 4K by 16 words
// - execution starts at address zero after reset
module mps_sequencer
#(
    parameter PC_W   = `MPS_PC_W,        // counter width
    parameter WORD_W = `MPS_WORD_W,      // program word width
    parameter ST_LVL = `MPS_STACK_DEPTH, // return stack levels
    parameter ST_AW  = `MPS_STACK_AW     // stack index width
)
(
    input  wire              i_ref_clk,     // system clock, 25 MHz
    input  wire              i_nrst,        // async reset, active low
    input  wire [WORD_W-1:0] i_prog_word,   // program memory read data
    input  wire              i_irq,         // enabled interrupt pending
    input  wire [PC_W-1:0]   i_irq_vector,  // interrupt entry address
    output reg  [PC_W-1:0]   o_prog_addr,   // program memory address
    output reg               o_fetch,       // one-cycle fetch pulse
    output reg  [1:0]        o_phase,       // current instruction phase
    output reg               o_exec_valid,  // low in the cycle after a dummy cycle
    output reg               o_irq_ack,     // one-cycle acknowledge
    output reg  [7:0]        o_acc,         // accumulator
    output reg  [3:0]        o_status,      // status flags
    output reg  [3:0]        o_stack_level  // saved levels, 0..8
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg  [PC_W-1:0]   pc;          // next fetch address
    reg  [PC_W-1:0]   fetch_addr;  // address of word now being fetched
    reg  [WORD_W-1:0] ir;          // instruction under execution
    reg               ir_valid;    // low turns the cycle into a dummy
    reg               hold;        // second cycle of an extended op
    reg  [ST_AW-1:0]  sp;          // next free stack slot
    wire [PC_W-1:0]   stk_top;     // registered top-of-stack data

    // ----------------------------------------------------------------
    // decode fields
    // ----------------------------------------------------------------
    wire [3:0] op     = ir[15:12];   // opcode
    wire [3:0] alu_op = ir[11:8];    // alu operation
    wire [7:0] imm    = ir[7:0];     // literal operand
    wire       full   = (o_stack_level == `MPS_STACK_FULL);
    wire       at_t4  = (o_phase == `MPS_PH_T4);

    // ----------------------------------------------------------------
    // alu: returns {status, result}
    // ----------------------------------------------------------------
    function [11:0] alu_f;
        input [3:0] fop;
        input [7:0] a;
        input [7:0] b;
        input [3:0] st;
        reg   [8:0] s;
        reg   [4:0] h;
        reg   [7:0] bb;
        reg   [7:0] r;
        reg   [3:0] n;
        reg         ci;
        reg         zup;
        begin
            n   = st;
            r   = a;
            zup = 1'b1;
            // subtract is add of the complement with carry in
            bb  = (fop == `MPS_ALU_SUB || fop == `MPS_ALU_SBC) ? ~b : b;
            case (fop)
                `MPS_ALU_ADD : ci = 1'b0;
                `MPS_ALU_SUB : ci = 1'b1;
                default      : ci = st[`MPS_ST_C];
            endcase
            s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
            h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
            case (fop)
                // arithmetic: carry is inverted borrow on subtract
                `MPS_ALU_ADD, `MPS_ALU_ADC, `MPS_ALU_SUB, `MPS_ALU_SBC :
                begin
                    r = s[7:0];
                    n[`MPS_ST_C]  = s[8];
                    n[`MPS_ST_AC] = h[4];
                    n[`MPS_ST_OV] = (a[7] == bb[7]) && (r[7] != a[7]);
                end
                `MPS_ALU_AND : r = a & b;
                `MPS_ALU_OR  : r = a | b;
                `MPS_ALU_XOR : r = a ^ b;
                `MPS_ALU_CPL : r = ~a;
                // rotates leave zero flag alone
                `MPS_ALU_RR  :
                begin
                    r   = {a[0], a[7:1]};
                    zup = 1'b0;
                end
                `MPS_ALU_RL  :
                begin
                    r   = {a[6:0], a[7]};
                    zup = 1'b0;
                end
                `MPS_ALU_RRC :
                begin
                    r   = {st[`MPS_ST_C], a[7:1]};
                    n[`MPS_ST_C] = a[0];
                    zup = 1'b0;
                end
                `MPS_ALU_RLC :
                begin
                    r   = {a[6:0], st[`MPS_ST_C]};
                    n[`MPS_ST_C] = a[7];
                    zup = 1'b0;
                end
                `MPS_ALU_INC : r = a + 8'h01;
                `MPS_ALU_DEC : r = a - 8'h01;
                `MPS_ALU_MOV :
                begin
                    r   = b;
                    zup = 1'b0;
                end
                default      : zup = 1'b0;
            endcase
            if (zup)
                n[`MPS_ST_Z] = (r == 8'h00);
            alu_f = {n, r};
        end
    endfunction

    wire [11:0] alu_res = alu_f(alu_op, o_acc, imm, o_status);
    wire [7:0]  acc_inc = o_acc + 8'h01;
    wire [7:0]  acc_dec = o_acc - 8'h01;

    // ----------------------------------------------------------------
    // execute decision, evaluated for the edge that ends the last phase
    // ----------------------------------------------------------------
    reg            next_redir;   // counter loads a target
    reg [PC_W-1:0] next_target;  // target address
    reg            next_drop;    // discard the fetched word
    reg            next_push;    // save a return address
    reg            next_pop;     // restore from stack
    reg            next_ext;     // extended op needs a hold cycle
    reg            next_ack;     // interrupt acknowledged
    reg [7:0]      next_acc;     // accumulator result
    reg [3:0]      next_status;  // status result

    // one process decides the whole cycle so priorities stay visible
    always @*
    begin
        next_redir  = 1'b0;
        next_target = pc;
        next_drop   = 1'b0;
        next_push   = 1'b0;
        next_pop    = 1'b0;
        next_ext    = 1'b0;
        next_ack    = 1'b0;
        next_acc    = o_acc;
        next_status = o_status;
        if (ir_valid && !hold)
        begin
            case (op)
                `MPS_OP_ALU  :
                    {next_status, next_acc} = alu_res;
                `MPS_OP_EXT  :
                begin
                    {next_status, next_acc} = alu_res;
                    next_ext = 1'b1;
                end
                // low byte write: jump inside the current page
                `MPS_OP_WPCL :
                begin
                    next_redir  = 1'b1;
                    next_target = {fetch_addr[PC_W-1:8], o_acc};
                end
                // only the low byte is visible to software
                `MPS_OP_RPCL : next_acc = fetch_addr[7:0];
                `MPS_OP_JMP  :
                begin
                    next_redir  = 1'b1;
                    next_target = ir[PC_W-1:0];
                end
                `MPS_OP_CALL :
                begin
                    next_redir  = 1'b1;
                    next_target = ir[PC_W-1:0];
                    next_push   = 1'b1;
                end
                `MPS_OP_RET, `MPS_OP_INTERRUPT_RETURN :
                begin
                    next_redir  = 1'b1;
                    next_target = stk_top;
                    next_pop    = 1'b1;
                end
                `MPS_OP_SZ   : next_drop = (o_acc == 8'h00);
                `MPS_OP_SNZ  : next_drop = (o_acc != 8'h00);
                `MPS_OP_SIZA :
                begin
                    next_acc  = acc_inc;
                    next_drop = (acc_inc == 8'h00);
                end
                `MPS_OP_SDZA :
                begin
                    next_acc  = acc_dec;
                    next_drop = (acc_dec == 8'h00);
                end
                default      : next_drop = 1'b0;
            endcase
        end
        // interrupt waits while the stack is full; a return frees a level
        // and the next boundary takes it
        if (i_irq && !full && !hold && !next_redir && !next_drop
            && !next_ext)
        begin
            next_ack    = 1'b1;
            next_push   = 1'b1;
            next_redir  = 1'b1;
            next_target = i_irq_vector;
        end
    end

    // ----------------------------------------------------------------
    // phase counter
    // ----------------------------------------------------------------
    // free-running: every cycle of i_ref_clk is one phase
    always @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_phase <= `MPS_PH_T1;
        else
            o_phase <= o_phase + 2'h1;
    end

    // ----------------------------------------------------------------
    // counter, fetch and instruction register
    // ----------------------------------------------------------------
    // reset presents the vector at once, so pc already holds vector + 1
    // and the first cycle runs as a dummy while word zero arrives
    always @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_prog_addr  <= `MPS_RESET_VECTOR;
            fetch_addr   <= `MPS_RESET_VECTOR;
            pc           <= `MPS_RESET_VECTOR + 12'h001;
            ir           <= 16'h0000;
            ir_valid     <= 1'b0;
            hold         <= 1'b0;
            o_fetch      <= 1'b0;
            o_exec_valid <= 1'b0;
            o_irq_ack    <= 1'b0;
            o_acc        <= 8'h00;
            o_status     <= 4'h0;
        end
        else if (at_t4)
        begin
            o_irq_ack    <= next_ack;
            o_exec_valid <= ir_valid;
            if (hold)
            begin
                // second cycle of an extended op: nothing fetched
                hold    <= 1'b0;
                o_fetch <= 1'b0;
            end
            else
            begin
                o_acc    <= next_acc;
                o_status <= next_status;
                hold     <= next_ext;
                // word fetched this cycle becomes the next to run;
                // a transfer or skip turns it into a dummy
                ir       <= i_prog_word;
                ir_valid <= !(next_redir || next_drop);
                // counter steps at the start of the first phase
                o_fetch  <= 1'b1;
                if (next_redir)
                begin
                    o_prog_addr <= next_target;
                    fetch_addr  <= next_target;
                    pc          <= next_target + 12'h001;
                end
                else
                begin
                    o_prog_addr <= pc;
                    fetch_addr  <= pc;
                    pc          <= pc + 12'h001;
                end
            end
        end
        else
        begin
            o_fetch   <= 1'b0;
            o_irq_ack <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // return stack pointer and level count
    // ----------------------------------------------------------------
    // circular slots: a push on a full stack overwrites the oldest value
    // and the level count saturates at the depth
    always @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sp            <= {ST_AW{1'b0}};
            o_stack_level <= 4'h0;
        end
        else if (at_t4 && !hold)
        begin
            if (next_push)
            begin
                sp <= sp + 3'h1;
                if (!full)
                    o_stack_level <= o_stack_level + 4'h1;
            end
            else if (next_pop)
            begin
                sp <= sp - 3'h1;
                if (o_stack_level != 4'h0)
                    o_stack_level <= o_stack_level - 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // return stack storage, no software path in or out
    // ----------------------------------------------------------------
    wire stk_wr = at_t4 && !hold && next_push;
    wire [ST_AW-1:0] stk_rd_addr = sp - 3'h1;

    // the saved value is the address of the word that would have run
    mps_stack_ram
    #(
        .DEPTH (ST_LVL),
        .AW    (ST_AW),
        .DW    (PC_W)
    )
    u_stack
    (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_wr_en   (stk_wr),
        .i_wr_addr (sp),
        .i_wr_data (fetch_addr),
        .i_rd_addr (stk_rd_addr),
        .o_rd_data (stk_top)
    );

endmodule

// ### design/mps_stack_ram.v
// return stack storage: small register array, registered read data.
// assumes one clock; the read port follows i_rd_addr one edge later.
`timescale 1ns/10ps

module mps_stack_ram
#(
    parameter DEPTH = 8,                 // levels
    parameter AW    = 3,                 // index width
    parameter DW    = 12                 // saved counter width
)
(
    input  wire          i_ref_clk,      // system clock
    input  wire          i_nrst,         // async reset, active low
    input  wire          i_wr_en,        // write strobe
    input  wire [AW-1:0] i_wr_addr,      // write slot
    input  wire [DW-1:0] i_wr_data,      // counter value to save
    input  wire [AW-1:0] i_rd_addr,      // slot to read
    output reg  [DW-1:0] o_rd_data       // registered read data
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    reg [DW-1:0] mem [0:DEPTH-1];        // array, not reset on purpose

    // write port: no reset so the array maps onto plain storage
    always @(posedge i_ref_clk)
    begin
        if (i_wr_en)
            mem[i_wr_addr] <= i_wr_data;
    end

    // read port: output comes from a register
    always @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_rd_data <= {DW{1'b0}};
        else
            o_rd_data <= mem[i_rd_addr];
    end

endmodule

// ### shared/mps_consts.vh
// constants for the program sequencer core: phases, opcodes, alu
// operations, status bit positions, reset vector and stack depth.
// assumes plain verilog-2005 and inclusion by bare name.
`ifndef MPS_CONSTS_VH
`define MPS_CONSTS_VH

// ----------------------------------------------------------------
// instruction phases and memory shape
// ----------------------------------------------------------------
`define MPS_PH_T1        2'h0
`define MPS_PH_T4        2'h3
`define MPS_PC_W         12
`define MPS_WORD_W       16
`define MPS_RESET_VECTOR 12'h000
`define MPS_STACK_DEPTH  8
`define MPS_STACK_AW     3
`define MPS_STACK_FULL   4'h8

// ----------------------------------------------------------------
// opcodes in word bits 15:12
// ----------------------------------------------------------------
`define MPS_OP_NOP  4'h0
`define MPS_OP_ALU  4'h1
`define MPS_OP_EXT  4'h2
`define MPS_OP_WPCL 4'h3
`define MPS_OP_RPCL 4'h4
`define MPS_OP_JMP  4'h5
`define MPS_OP_CALL 4'h6
`define MPS_OP_RET  4'h7
`define MPS_OP_INTERRUPT_RETURN 4'h8
`define MPS_OP_SZ   4'h9
`define MPS_OP_SNZ  4'hA
`define MPS_OP_SIZA 4'hB
`define MPS_OP_SDZA 4'hC

// ----------------------------------------------------------------
// alu operations in word bits 11:8, operand in bits 7:0
// ----------------------------------------------------------------
`define MPS_ALU_ADD 4'h0
`define MPS_ALU_ADC 4'h1
`define MPS_ALU_SUB 4'h2
`define MPS_ALU_SBC 4'h3
`define MPS_ALU_AND 4'h4
`define MPS_ALU_OR  4'h5
`define MPS_ALU_XOR 4'h6
`define MPS_ALU_CPL 4'h7
`define MPS_ALU_RR  4'h8
`define MPS_ALU_RL  4'h9
`define MPS_ALU_RRC 4'hA
`define MPS_ALU_RLC 4'hB
`define MPS_ALU_INC 4'hC
`define MPS_ALU_DEC 4'hD
`define MPS_ALU_MOV 4'hE

// ----------------------------------------------------------------
// status register bit positions
// ----------------------------------------------------------------
`define MPS_ST_C  0
`define MPS_ST_AC 1
`define MPS_ST_Z  2
`define MPS_ST_OV 3

`endif

// ### testbench/mps_prog_mem.sv
// program memory and interrupt request model facing the sequencer
// assumes the bench loads mem directly before releasing reset
`timescale 1ns/10ps

module mps_prog_mem
#(
    parameter VECTOR = 12'hF00             // interrupt entry, plain default
)
(
    input  wire        i_ref_clk,          // system clock
    input  wire [11:0] i_addr,             // fetch address
    input  wire        i_raise,            // bench request pulse
    input  wire        i_ack,              // acknowledge from the core
    output reg  [15:0] o_word,             // read data, one clock late
    output reg         o_irq,              // request held until acknowledged
    output wire [11:0] o_vector            // entry address
);
    reg [15:0] mem [0:4095];               // 4K words of 16 bits

    assign o_vector = VECTOR;
    initial o_irq = 1'b0;

    // registered read: well inside the three clocks the core allows
    always @(posedge i_ref_clk)
        o_word <= mem[i_addr];

    // request flag stays recorded until the core acknowledges it
    always @(posedge i_ref_clk)
    begin
        if (i_raise)
            o_irq <= 1'b1;
        else if (i_ack)
            o_irq <= 1'b0;
    end
endmodule

// ### testbench/mps_sequencer_monitor.sv
// port checker for the program sequencer core, bound to its top module
// assumes one clock domain and the active-low asynchronous reset
`timescale 1ns/10ps
`include "mps_consts.vh"

module mps_sequencer_monitor
#(
    parameter PC_W   = 12,                 // counter width
    parameter WORD_W = 16                  // program word width
)
(
    input wire              i_ref_clk,     // system clock
    input wire              i_nrst,        // async reset, active low
    input wire [WORD_W-1:0] i_prog_word,   // memory data
    input wire              i_irq,         // pending request
    input wire [PC_W-1:0]   i_irq_vector,  // entry address
    input wire [PC_W-1:0]   o_prog_addr,   // fetch address
    input wire              o_fetch,       // fetch pulse
    input wire [1:0]        o_phase,       // instruction phase
    input wire              o_exec_valid,  // real or dummy cycle
    input wire              o_irq_ack,     // acknowledge pulse
    input wire [7:0]        o_acc,         // accumulator
    input wire [3:0]        o_status,      // flags
    input wire [3:0]        o_stack_level  // saved levels
);
    reg [2:0] warm;                        // edges since release, saturates

    // ----------------------------------------------------------------
    // helper: counts the first edges after reset release
    // ----------------------------------------------------------------
    always @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            warm <= 3'h0;
        else if (warm != 3'h7)
            warm <= warm + 3'h1;
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);

    // request seen at the last phase with room on the stack
    sequence seq_irq_seen;
        (o_phase == `MPS_PH_T4) && i_irq && (o_stack_level < `MPS_STACK_FULL);
    endsequence
    // acknowledge lands with a fetch at the first phase
    sequence seq_ack_entry;
        o_irq_ack && o_fetch && (o_phase == `MPS_PH_T1);
    endsequence

    // the first edge after release still sees the reset value twice
    chk_phase_step: assert property ((warm != 3'h0) |->
        o_phase == $past(o_phase) + 2'h1)
        else $error("phase did not step by one");
    chk_fetch_first: assert property (o_fetch |-> o_phase == `MPS_PH_T1)
        else $error("fetch outside first phase");
    chk_addr_hold: assert property ((o_phase != `MPS_PH_T1) |-> $stable(o_prog_addr))
        else $error("address moved inside a cycle");
    chk_ack_vector: assert property (seq_irq_seen ##1 seq_ack_entry |->
        (o_prog_addr == i_irq_vector) ##1 !o_irq_ack)
        else $error("acknowledge without vector or too long");
    chk_ack_cause: assert property (o_irq_ack |->
        $past(i_irq) && ($past(o_phase) == `MPS_PH_T4))
        else $error("acknowledge without request");
    chk_ack_push: assert property (o_irq_ack |->
        o_stack_level == $past(o_stack_level) + 4'h1)
        else $error("acknowledge did not push");
    chk_full_block: assert property (($past(o_stack_level) == `MPS_STACK_FULL) |-> !o_irq_ack)
        else $error("acknowledge on full stack");
    chk_level_cap: assert property (o_stack_level <= `MPS_STACK_FULL)
        else $error("stack level above depth");
    chk_reset_vector: assert property ((warm < 3'h3) |->
        (o_prog_addr == `MPS_RESET_VECTOR) && !o_fetch && !o_exec_valid)
        else $error("first cycle not at address zero");
endmodule

bind mps_sequencer mps_sequencer_monitor #(.PC_W(PC_W), .WORD_W(WORD_W)) i_mps_sequencer_monitor
(
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_prog_word(i_prog_word), .i_irq(i_irq),
    .i_irq_vector(i_irq_vector), .o_prog_addr(o_prog_addr), .o_fetch(o_fetch),
    .o_phase(o_phase), .o_exec_valid(o_exec_valid), .o_irq_ack(o_irq_ack),
    .o_acc(o_acc), .o_status(o_status), .o_stack_level(o_stack_level)
);

// ### testbench/tb.sv
// self-checking bench for the program sequencer core
// assumes the memory model and the bound port checker
`timescale 1ns/10ps

module tb;
    reg          i_ref_clk;                // 25 MHz clock
    reg          i_nrst;                   // async reset, active low
    reg          raise;                    // request pulse
    wire [15:0]  word;
    wire         irq;
    wire [11:0]  vector;
    wire [11:0]  addr;
    wire         fetch;
    wire         exec_valid;
    wire         ack;
    wire [7:0]   acc;
    wire [3:0]   status;
    wire [3:0]   level;
    integer      n_fail = 0;
    integer      samples_checked = 0;
    integer      cyc = 0;                  // clocks seen
    integer      acks = 0;                 // acknowledges seen
    logic [11:0] fa [$];                   // fetched addresses
    integer      ft [$];                   // clock of each fetch

    mps_sequencer i_mps_sequencer (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_prog_word(word), .i_irq(irq), .i_irq_vector(vector), .o_prog_addr(addr),
        .o_fetch(fetch), .o_phase(), .o_exec_valid(exec_valid), .o_irq_ack(ack),
        .o_acc(acc), .o_status(status), .o_stack_level(level));
    mps_prog_mem i_mps_prog_mem (.i_ref_clk(i_ref_clk), .i_addr(addr), .i_raise(raise),
        .i_ack(ack), .o_word(word), .o_irq(irq), .o_vector(vector));

    initial
    begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    // recorder: reset cycle fetch of zero carries no pulse, so it is absent
    always @(posedge i_ref_clk)
    begin
        cyc <= cyc + 1;
        if (i_nrst === 1'b1 && ack === 1'b1)
            acks <= acks + 1;
        if (i_nrst === 1'b1 && fetch === 1'b1)
        begin
            fa.push_back(addr);
            ft.push_back(cyc);
        end
    end

    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // enter reset and blank the program
    task clr();
        integer k;
        @(posedge i_ref_clk);
        #1;
        i_nrst = 1'b0;
        for (k = 0; k < 4096; k = k + 1)
            i_mps_prog_mem.mem[k] = 16'h0000;
        fa.delete();
        ft.delete();
        acks = 0;
    endtask

    // release after two clocks, then run n clocks
    task go(input integer n);
        repeat (2) @(posedge i_ref_clk);
        #1;
        i_nrst = 1'b1;
        chk("level at reset", {12'h000, level}, 16'h0000);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    // add, extended load keeping flags, taken skip over a load
    task s_alu_skip();
        integer i;
        clr();
        i_mps_prog_mem.mem[0] = 16'h1E7F;
        i_mps_prog_mem.mem[1] = 16'h1001;
        i_mps_prog_mem.mem[2] = 16'h2E00;
        i_mps_prog_mem.mem[3] = 16'h9000;
        i_mps_prog_mem.mem[4] = 16'h1E55;
        go(48);
        chk("acc", {8'h00, acc}, 16'h0000);
        chk("status", {12'h000, status}, 16'h000A);
        chk("real cycle", {15'h0000, exec_valid}, 16'h0001);
        for (i = 0; i < 7; i = i + 1)
            chk("fetch", {4'h0, fa[i]}, 16'(i + 1));
        chk("plain gap", 16'(ft[2] - ft[1]), 16'h0004);
        chk("hold gap", 16'(ft[4] - ft[3]), 16'h0008);
    endtask

    // call, page write of the low byte, low byte read, return
    task s_branch();
        logic [11:0] e [9] = '{12'h001, 12'h2F0, 12'h2F1, 12'h2F2, 12'h210,
                              12'h211, 12'h212, 12'h001, 12'h002};
        integer i;
        clr();
        i_mps_prog_mem.mem[0] = 16'h62F0;
        i_mps_prog_mem.mem[12'h2F0] = 16'h1E10;
        i_mps_prog_mem.mem[12'h2F1] = 16'h3000;
        i_mps_prog_mem.mem[12'h210] = 16'h4000;
        i_mps_prog_mem.mem[12'h211] = 16'h7000;
        go(48);
        for (i = 0; i < 9; i = i + 1)
            chk("branch fetch", {4'h0, fa[i]}, {4'h0, e[i]});
        chk("low byte read", {8'h00, acc}, 16'h0011);
        chk("level", {12'h000, level}, 16'h0000);
    endtask

    // nine nested calls, request on full stack, returns drain it
    task s_stack();
        integer k;
        integer n11;
        integer nv;
        clr();
        for (k = 0; k < 9; k = k + 1)
            i_mps_prog_mem.mem[k * 16] = 16'h6000 | 16'((k + 1) * 16);
        for (k = 2; k < 9; k = k + 1)
            i_mps_prog_mem.mem[k * 16 + 1] = 16'h7000;
        i_mps_prog_mem.mem[12'h09C] = 16'h7000;
        i_mps_prog_mem.mem[12'h011] = 16'h50F0;
        i_mps_prog_mem.mem[12'h0F4] = 16'h50F4;
        i_mps_prog_mem.mem[12'hF00] = 16'h8000;
        go(80);
        chk("full level", {12'h000, level}, 16'h0008);
        raise = 1'b1;
        @(posedge i_ref_clk);
        #1;
        raise = 1'b0;
        repeat (12) @(posedge i_ref_clk);
        #1;
        chk("held ack", 16'(acks), 16'h0000);
        repeat (300) @(posedge i_ref_clk);
        #1;
        n11 = 0;
        nv = 0;
        foreach (fa[k])
        begin
            if (fa[k] === 12'h011)
                n11 = n11 + 1;
            if (fa[k] === 12'hF00)
                nv = nv + 1;
        end
        chk("late ack", 16'(acks), 16'h0001);
        chk("vector fetch", 16'(nv), 16'h0001);
        // once as the word dropped by the second call, once on return
        chk("return chain", 16'(n11), 16'h0002);
        chk("drained", {12'h000, level}, 16'h0000);
    endtask

    task final_report();
        if (n_fail == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        i_nrst = 1'b0;
        raise = 1'b0;
        s_alu_skip();
        s_branch();
        s_stack();
        final_report();
    end

    // watchdog: the scenarios need well under a thousand clocks
    initial
    begin
        #(40 * 4000);
        n_fail = n_fail + 1;
        final_report();
    end
endmodule
